// ### hw/rename_stall_pkg.sv
package rename_stall_pkg;

   localparam logic [7:0] EVT_RAT_STALL = 8'hd2;
   localparam logic [7:0] EVT_SEG_STALL = 8'hd4;

   // Unit mask bit positions under the rename-table code
   localparam int MASK_ROB_PORT_BIT = 0;
   localparam int MASK_PARTIAL_BIT = 1;
   localparam int MASK_FLAG_BIT = 2;
   localparam int MASK_FP_STATUS_WORD_BIT = 3;

   // Unit mask bit positions under the segment code
   localparam int MASK_SEG_E_BIT = 0;
   localparam int MASK_SEG_D_BIT = 1;
   localparam int MASK_SEG_F_BIT = 2;
   localparam int MASK_SEG_G_BIT = 3;

   localparam int CNT_W = 40;
   localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
   localparam logic [1:0] FP_STATUS_WORD_COUNTS_PER_WRITE = 2'h2;

   // Pipeline condition strobes
   typedef struct packed {
      logic rob_read_port_stall;
      logic partial_reg_read;
      logic flag_subset_write;
      logic flag_read_unmodified;
      logic flag_other_stall;
      logic fp_status_word_write;
   } rat_cond_t;

   typedef struct packed {
      logic [3:0] renamed_pending;
      logic [3:0] second_update;
      logic [3:0] retire;
   } seg_cond_t;

   typedef struct packed {
      logic [7:0] event_code;
      logic [3:0] unit_mask;
   } evt_sel_t;

endpackage : rename_stall_pkg

// ### hw/rename_stall_event_selector.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Code d2 mask 02 counts cycles a partially written register is read.
// - Code d2 mask 04 counts flag stall cycles, partial flag stalls too.
// - Partial flag stall: subset flag write and read of untouched flags in the same cycle.
// - Code d2 mask 08 gives two counts per status word write.
// - Code d2 mask 0f counts cycles with any rename-table stall condition.
// - Code d4 masks 01 and 02 count extra and data segment rename stalls.
// - Code d4 masks 04 and 08 count f and g segment rename stalls.
// - Code d4 mask 0f counts a rename stall of any of the four segments.
// - A second update to a renamed unretired segment stalls till retire.
// - The reorder read port condition is set in each cycle it blocks entry.
module rename_stall_event_selector
   import rename_stall_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire evt_sel_t sel_in,
   input wire rat_cond_t rat_in,
   input wire seg_cond_t seg_in,
   output logic [CNT_W-1:0] count_out,
   output logic [3:0] seg_stall_out,
   output logic hit_out
);

   logic [3:0] seg_stall_q;
   logic [3:0] seg_stall_d;
   logic fp_status_word_extra_q;
   logic fp_status_word_extra_d;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic hit_q;
   logic hit_d;
   logic [3:0] rat_vec;
   logic partial_flag;
   logic hit;

   // Segment stall group
   always_comb
   begin
      // Stall holds from second update until retire
      for (int i = 0; i < 4; i++)
      begin
         if (seg_in.retire[i])
         begin
            seg_stall_d[i] = 1'b0;
         end
         else if (seg_in.renamed_pending[i] && seg_in.second_update[i])
         begin
            seg_stall_d[i] = 1'b1;
         end
         else
         begin
            seg_stall_d[i] = seg_stall_q[i];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         seg_stall_q <= 4'h0;
      end
      else
      begin
         seg_stall_q <= seg_stall_d;
      end
   end

   // Event selection and counting group
   always_comb
   begin
      // Partial flag hazard
      partial_flag = rat_in.flag_subset_write
                     & rat_in.flag_read_unmodified;
      rat_vec = 4'h0;
      rat_vec[MASK_ROB_PORT_BIT] = rat_in.rob_read_port_stall;
      rat_vec[MASK_PARTIAL_BIT] = rat_in.partial_reg_read;
      rat_vec[MASK_FLAG_BIT] = partial_flag
                               | rat_in.flag_other_stall;
      rat_vec[MASK_FP_STATUS_WORD_BIT] = rat_in.fp_status_word_write;
      hit = 1'b0;
      if (sel_in.event_code == EVT_RAT_STALL)
      begin
         hit = |(rat_vec & sel_in.unit_mask);
      end
      else if (sel_in.event_code == EVT_SEG_STALL)
      begin
         hit = |(seg_stall_q & sel_in.unit_mask);
      end
      // Second count of a status word write lands next cycle
      fp_status_word_extra_d = (sel_in.event_code == EVT_RAT_STALL)
                     & sel_in.unit_mask[MASK_FP_STATUS_WORD_BIT]
                     & rat_in.fp_status_word_write;
      hit_d = hit | fp_status_word_extra_q;
      count_d = count_q;
      if (hit && fp_status_word_extra_q)
      begin
         count_d = count_q + CNT_W'(FP_STATUS_WORD_COUNTS_PER_WRITE);
      end
      else if (hit_d)
      begin
         count_d = count_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
      begin
         fp_status_word_extra_q <= 1'b0;
         count_q <= CNT_RESET;
         hit_q <= 1'b0;
      end
      else
      begin
         fp_status_word_extra_q <= fp_status_word_extra_d;
         count_q <= count_d;
         hit_q <= hit_d;
      end
   end

   assign count_out = count_q;
   assign seg_stall_out = seg_stall_q;
   assign hit_out = hit_q;

   a_partial_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h2} && rat_in.partial_reg_read
       && !fp_status_word_extra_q) |=> count_q == $past(count_q) + 1)
      else $error("partial stall not counted");
   a_flag_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h4} && rat_in.flag_subset_write
       && rat_in.flag_read_unmodified && !fp_status_word_extra_q)
      |=> count_q == $past(count_q) + 1)
      else $error("flag stall not counted");
   a_flag_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h4} && !rat_in.flag_other_stall
       && !(rat_in.flag_subset_write && rat_in.flag_read_unmodified)
       && !fp_status_word_extra_q) |=> $stable(count_q))
      else $error("flag count without hazard");
   a_fp_status_word_twice: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h8} && rat_in.fp_status_word_write
       && !fp_status_word_extra_q) ##1 (sel_in == {EVT_RAT_STALL, 4'h8}
       && !rat_in.fp_status_word_write)
      |=> count_q == $past(count_q, 2) + 2)
      else $error("status word write not counted twice");
   a_any_rat: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'hf} && rat_in.rob_read_port_stall)
      |=> hit_q)
      else $error("read port stall missed");
   a_seg_single: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in.event_code == EVT_SEG_STALL && !fp_status_word_extra_q
       && (seg_stall_q & sel_in.unit_mask) != 4'h0)
      |=> count_q == $past(count_q) + 1)
      else $error("segment stall not counted");
   a_seg_any: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_SEG_STALL, 4'hf} && seg_stall_q == 4'h0
       && !fp_status_word_extra_q) |=> $stable(count_q))
      else $error("segment count without stall");
   a_seg_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (seg_in.renamed_pending[0] && seg_in.second_update[0]
       && !seg_in.retire[0]) ##1 !seg_in.retire[0] |=> seg_stall_q[0])
      else $error("segment stall released early");
   a_no_match: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in.event_code != EVT_RAT_STALL
       && sel_in.event_code != EVT_SEG_STALL && !fp_status_word_extra_q)
      |=> $stable(count_q))
      else $error("count moved without code match");

   a_partial_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h2} && !rat_in.partial_reg_read
       && !fp_status_word_extra_q) |=> $stable(count_q))
      else $error("partial count without stall");
   a_mask_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in.unit_mask == 4'h0 && !fp_status_word_extra_q) |=> $stable(count_q))
      else $error("count moved with empty mask");
   a_any_once: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'hf} && !rat_in.fp_status_word_write
       && !fp_status_word_extra_q && (rat_in.rob_read_port_stall
       || rat_in.partial_reg_read || rat_in.flag_other_stall))
      |=> count_q == $past(count_q) + 1)
      else $error("combined stall not counted once");
   a_fp_status_word_first: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_RAT_STALL, 4'h8} && rat_in.fp_status_word_write
       && !fp_status_word_extra_q) |=> count_q == $past(count_q) + 1)
      else $error("status word write first count missing");
   a_seg_any_count: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (sel_in == {EVT_SEG_STALL, 4'hf} && seg_stall_q != 4'h0
       && !fp_status_word_extra_q) |=> count_q == $past(count_q) + 1)
      else $error("combined segment stall not counted");
   a_hit_marks: assert property (@(posedge clk_in) disable iff (!resetn_in)
      hit_q == (count_q != $past(count_q)))
      else $error("hit flag disagrees with counter");

   // Per segment set, release and quiet
   for (genvar s = 0; s < 4; s++)
   begin : g_seg_check
      a_seg_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
         (seg_in.renamed_pending[s] && seg_in.second_update[s]
          && !seg_in.retire[s]) |=> seg_stall_q[s])
         else $error("segment stall not raised");
      a_seg_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
         seg_in.retire[s] |=> !seg_stall_q[s])
         else $error("segment stall held past retire");
      a_seg_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
         (!seg_stall_q[s] && !(seg_in.renamed_pending[s]
          && seg_in.second_update[s])) |=> !seg_stall_q[s])
         else $error("segment stall without second update");
   end

   c_fp_status_word: cover property (@(posedge clk_in) disable iff (!resetn_in)
      sel_in.unit_mask[MASK_FP_STATUS_WORD_BIT] && rat_in.fp_status_word_write);
   c_seg_release: cover property (@(posedge clk_in) disable iff (!resetn_in)
      seg_stall_q[2] ##1 !seg_stall_q[2]);
   c_multi: cover property (@(posedge clk_in) disable iff (!resetn_in)
      sel_in == {EVT_RAT_STALL, 4'hf} && rat_in.partial_reg_read
      && rat_in.rob_read_port_stall);
   c_flag_hazard: cover property (@(posedge clk_in) disable iff (!resetn_in)
      sel_in == {EVT_RAT_STALL, 4'h4} && rat_in.flag_subset_write
      && rat_in.flag_read_unmodified);
   c_fp_status_word_pair: cover property (@(posedge clk_in) disable iff (!resetn_in)
      hit && fp_status_word_extra_q);

endmodule : rename_stall_event_selector

// ### verif/rename_stall_event_selector_tb.sv
`timescale 1ns/10ps
module rename_stall_event_selector_tb
   import rename_stall_pkg::*;
();
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   evt_sel_t sel_in = '0;
   rat_cond_t rat_in = '0;
   seg_cond_t seg_in = '0;
   logic [CNT_W-1:0] count_out;
   logic [CNT_W-1:0] base;
   logic [3:0] seg_stall_out;
   logic hit_out;
   int err_total = 0;
   int compares = 0;
   always #25 clk_in = ~clk_in;
   rename_stall_event_selector dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .sel_in(sel_in), .rat_in(rat_in), .seg_in(seg_in),
      .count_out(count_out), .seg_stall_out(seg_stall_out),
      .hit_out(hit_out));
   task check(input logic [CNT_W-1:0] seen, exp, input string m);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %0t %s seen %0h exp %0h", $time, m, seen, exp);
      end
   endtask : check
   task cyc(input evt_sel_t s, input logic [5:0] r, input logic [11:0] g);
      @(posedge clk_in);
      sel_in <= s;
      rat_in <= rat_cond_t'(r);
      seg_in <= seg_cond_t'(g);
   endtask : cyc
   // Quiet cycles, then remember the count
   task start(input evt_sel_t s);
      repeat (3) cyc(s, 6'h00, 12'h000);
      @(negedge clk_in);
      base = count_out;
   endtask : start
   task delta(input logic [CNT_W-1:0] exp, input string m);
      repeat (3) cyc(sel_in, 6'h00, 12'h000);
      @(negedge clk_in);
      check(count_out - base, exp, m);
      $display("test %s done", m);
   endtask : delta
   task final_report;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   initial
   begin
      #100us;
      err_total++;
      final_report();
   end
   initial
   begin
      logic [3:0] mk;
      logic [CNT_W-1:0] want;
      repeat (4) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      check(count_out, CNT_RESET, "reset count");
      check({36'h0, seg_stall_out}, 40'h0, "reset stall");
      check({39'h0, hit_out}, 40'h0, "reset hit");
      start({EVT_RAT_STALL, 4'h2});
      cyc(sel_in, 6'h10, 12'h000);
      cyc(sel_in, 6'h00, 12'h000);
      @(negedge clk_in);
      check({39'h0, hit_out}, 40'h1, "hit");
      check(count_out - base, 40'h1, "partial one");
      repeat (2) cyc(sel_in, 6'h10, 12'h000);
      delta(40'h3, "partial");
      start({EVT_RAT_STALL, 4'h4});
      cyc(sel_in, 6'h02, 12'h000);
      cyc(sel_in, 6'h10, 12'h000);
      cyc(sel_in, 6'h22, 12'h000);
      cyc(sel_in, 6'h08, 12'h000);
      cyc(sel_in, 6'h04, 12'h000);
      cyc(sel_in, 6'h0c, 12'h000);
      delta(40'h3, "flag");
      start({EVT_RAT_STALL, 4'h8});
      cyc(sel_in, 6'h01, 12'h000);
      cyc(sel_in, 6'h00, 12'h000);
      repeat (2) cyc(sel_in, 6'h01, 12'h000);
      delta(40'h6, "status word");
      start({EVT_RAT_STALL, 4'hf});
      cyc(sel_in, 6'h20, 12'h000);
      cyc(sel_in, 6'h32, 12'h000);
      delta(40'h2, "any rat");
      for (int k = 0; k < 2; k++)
      begin
         start(k == 0 ? {8'hd3, 4'hf} : {EVT_RAT_STALL, 4'h0});
         cyc(sel_in, 6'h3f, 12'h000);
         delta(40'h0, "no match");
      end
      for (int i = 0; i < 4; i++)
         for (int j = 0; j < 3; j++)
         begin
            mk = j == 0 ? 4'(1 << i) : j == 1 ? 4'hf : 4'(1 << ((i + 1) % 4));
            // Stall spans five sampled cycles up to retire
            want = j == 2 ? 40'h0 : 40'h5;
            start({EVT_SEG_STALL, mk});
            cyc(sel_in, 6'h00, {4'(1 << i), 4'(1 << i), 4'h0});
            cyc(sel_in, 6'h00, {4'(1 << i), 8'h00});
            @(negedge clk_in);
            check({36'h0, seg_stall_out}, 40'(1 << i), "seg stall");
            repeat (3) cyc(sel_in, 6'h00, {4'(1 << i), 8'h00});
            cyc(sel_in, 6'h00, {8'h00, 4'(1 << i)});
            cyc(sel_in, 6'h00, 12'h000);
            @(negedge clk_in);
            check({36'h0, seg_stall_out}, 40'h0, "seg retire");
            check(count_out - base, want, "seg");
            delta(want, "seg count");
         end
      final_report();
   end
endmodule : rename_stall_event_selector_tb
